//--- src/nco_pll_pkg.sv
// Shared constants and types for the mixer oscillator and synthesiser register bank.
package nco_pll_pkg;

   // Register indices; the AHB byte address is four times the index.
   localparam logic [7:0] IDX_AB_PHASE = 8'h12;
   localparam logic [7:0] IDX_CD_PHASE = 8'h13;
   localparam logic [7:0] IDX_AB_FREQ_LO = 8'h14;
   localparam logic [7:0] IDX_AB_FREQ_HI = 8'h15;
   localparam logic [7:0] IDX_CD_FREQ_LO = 8'h16;
   localparam logic [7:0] IDX_CD_FREQ_HI = 8'h17;
   localparam logic [7:0] IDX_SYNTH = 8'h18;
   localparam logic [7:0] IDX_AUTOSYNC = 8'h1F;

   // Address bits that carry the register index.
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_W = 8;

   // Widths of the oscillator words.
   localparam int unsigned FREQ_W = 32;
   localparam int unsigned PHASE_W = 16;
   localparam int unsigned HALF_W = 16;

   // Reset values of the mixer registers.
   localparam logic [15:0] FREQ_HALF_RST = 16'h0000;
   localparam logic [15:0] PHASE_RST = 16'h0000;

   // Auto-sync control field positions and reset value.
   localparam int unsigned ASYNC_AB_BIT = 0;
   localparam int unsigned ASYNC_CD_BIT = 1;
   localparam logic [1:0] ASYNC_RST = 2'h3;

   // Charge pump selection codes.
   localparam logic [1:0] CP_NONE = 2'h0;
   localparam logic [1:0] CP_SINGLE = 2'h1;
   localparam logic [1:0] CP_UNUSED = 2'h2;
   localparam logic [1:0] CP_DUAL = 2'h3;

   // Prescaler code that selects the largest ratio, and that ratio.
   localparam logic [2:0] PRESC_DIV8_CODE = 3'h0;
   localparam logic [3:0] PRESC_DIV8 = 4'h8;

   // Synthesiser control and status layout, most significant field first.
   typedef struct packed {
      logic [2:0] resv_hi;
      logic lf_clear;
      logic ndiv_sync_ena;
      logic pll_ena;
      logic [1:0] resv_lo;
      logic [1:0] charge_pump;
      logic [2:0] prescale;
      logic [2:0] lf_volt;
   } pll_ctrl_t;

   // Reset values of the synthesiser fields.
   localparam logic [2:0] RESV_HI_RST = 3'h1;
   localparam logic LF_CLEAR_RST = 1'b0;
   localparam logic NDIV_SYNC_RST = 1'b1;
   localparam logic PLL_ENA_RST = 1'b0;
   localparam logic [1:0] RESV_LO_RST = 2'h0;
   localparam logic [1:0] CP_RST = 2'h0;
   localparam logic [2:0] PRESC_RST = 3'h1;
   localparam logic [2:0] LF_VOLT_RST = 3'h0;

   // One oscillator's settings: frequency word and phase shift.
   typedef struct packed {
      logic [31:0] freq;
      logic [15:0] phase;
   } mixer_cfg_t;

endpackage : nco_pll_pkg

//--- src/nco_accum.sv
// Phase accumulator of one fine-mixer oscillator with its table address output.
`timescale 1ns/100ps
module nco_accum #(
   parameter int unsigned ACC_W = 32,
   parameter int unsigned PHASE_W = 16
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Sample timing and active settings.
   input wire logic advance,
   input wire logic [ACC_W-1:0] freq_word,
   input wire logic [PHASE_W-1:0] phase_shift,
   // Sine and cosine table address.
   output logic [PHASE_W-1:0] lut_addr
);

   logic [ACC_W-1:0] acc_ff;
   logic [PHASE_W-1:0] lut_addr_ff;

   // A same-width add wraps modulo two to the accumulator width, so a negative word
   // in two's complement steps the phase backwards; one step is the sample rate over 2^32.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_ff <= '0;
      end else if (advance) begin
         acc_ff <= acc_ff + freq_word;
      end
   end

   // The phase shift is added to the upper bits of the accumulator result.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lut_addr_ff <= '0;
      end else begin
         lut_addr_ff <= acc_ff[ACC_W-1 -: PHASE_W] + phase_shift;
      end
   end

   assign lut_addr = lut_addr_ff;

endmodule : nco_accum

//--- src/nco_pll_config_regs.sv
// Fine-mixer oscillator and clock synthesiser configuration registers on AHB-Lite.
//
// Notes on behaviour
// - Each CD table address is the CD phase shift plus the upper 16 accumulator bits.
// - With CD auto-sync on, a CD phase-shift write loads CD phase and both frequency halves.
// - CD frequency-half writes alone leave the active mixer unchanged; phase goes last.
// - Frequency words are two's complement, so negative words turn the phase backwards.
// - One step of a frequency word is the sample rate divided by two to the 32nd.
// - The AB frequency word is 32 bits in a low and a high half, both resetting to zero.
// - The CD frequency word is 32 bits in a low and a high half, both resetting to zero.
// - While the loop-filter clear bit is set the loop filter is held at ground.
// - With the divider align bit set, reset value one, the LVDS sync aligns the N dividers.
// - The PLL enable bit runs the PLL when set and bypasses it when clear, resetting to zero.
// - Charge pump code 00 is none, 01 single, 11 dual, 10 unused, resetting to 00.
// - Prescaler codes 010 to 111 divide by 2 to 7, code 000 by 8, resetting to 001.
// - Bits 2:0 read back the loop-filter voltage indicator, which software cannot write.
// - Reserved bits 15:13 reset to 001 and bits 9:8 to 00, and hold what software writes.
// - With AB auto-sync on, an AB phase-shift write loads AB phase and both frequency halves.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module nco_pll_config_regs (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave port.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Mixer timing.
   input wire logic sample_strobe,
   input wire logic ext_mixer_sync,
   // Mixer table addresses and load indications.
   output logic [15:0] ab_lut_addr,
   output logic [15:0] cd_lut_addr,
   output logic ab_mixer_loaded,
   output logic cd_mixer_loaded,
   // Synthesiser inputs.
   input wire logic lvds_sync,
   input wire logic [2:0] lf_volt_code,
   // Synthesiser controls.
   output logic pll_lf_clamp,
   output logic pll_ndiv_sync,
   output logic pll_enable,
   output logic pll_bypass,
   output logic cp_single,
   output logic cp_dual,
   output logic [3:0] prescale_ratio
);

   // Decoded address phase.
   logic addr_valid;
   logic [7:0] addr_idx;

   // Data phase bookkeeping.
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [7:0] dp_idx_ff;

   // Staged mixer registers, as software sees them.
   nco_pll_pkg::mixer_cfg_t ab_stage_ff;
   nco_pll_pkg::mixer_cfg_t cd_stage_ff;
   nco_pll_pkg::mixer_cfg_t nxt_ab_stage;
   nco_pll_pkg::mixer_cfg_t nxt_cd_stage;

   // Active mixer settings that drive the accumulators.
   nco_pll_pkg::mixer_cfg_t ab_active_ff;
   nco_pll_pkg::mixer_cfg_t cd_active_ff;

   // Auto-sync enables and the load decisions.
   logic [1:0] autosync_ff;
   logic ab_load;
   logic cd_load;
   logic ab_loaded_ff;
   logic cd_loaded_ff;

   // Synthesiser control and status.
   nco_pll_pkg::pll_ctrl_t pll_ctrl_ff;
   logic [2:0] lf_volt_ff;
   logic ndiv_sync_ff;
   logic [3:0] prescale_ratio_ff;

   // Read data mux output.
   logic [15:0] rd_word;

   // True when the pending write targets the given register.
   function automatic logic wr_hit(input logic pend, input logic [7:0] idx,
                                   input logic [7:0] target);
      wr_hit = pend && (idx == target);
   endfunction : wr_hit

   // Division ratio for a prescaler code; code 000 gives the largest ratio.
   function automatic logic [3:0] presc_ratio(input logic [2:0] code);
      if (code == nco_pll_pkg::PRESC_DIV8_CODE) begin
         presc_ratio = nco_pll_pkg::PRESC_DIV8;
      end else begin
         presc_ratio = {1'b0, code};
      end
   endfunction : presc_ratio

   // The slave never stretches a transfer and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // A transfer is taken when selected, ready and NONSEQ or SEQ.
   assign addr_valid = hsel && hready && htrans[1];
   assign addr_idx = haddr[nco_pll_pkg::IDX_LSB +: nco_pll_pkg::IDX_W];

   // Capture the address phase for use in the following data phase.
   // This slave never stretches, but the hready gate keeps the capture right when another
   // slave on the same bus inserts wait states.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         dp_idx_ff <= 8'h00;
      end else if (hready) begin
         wr_pend_ff <= addr_valid && hwrite;
         rd_pend_ff <= addr_valid && !hwrite;
         dp_idx_ff <= addr_idx;
      end
   end

   // Staged AB values with the current data-phase write folded in.
   always_comb begin
      nxt_ab_stage = ab_stage_ff;
      if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_AB_PHASE)) begin
         nxt_ab_stage.phase = hwdata[15:0];
      end
      if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_AB_FREQ_LO)) begin
         nxt_ab_stage.freq[15:0] = hwdata[15:0];
      end
      if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_AB_FREQ_HI)) begin
         nxt_ab_stage.freq[31:16] = hwdata[15:0];
      end
   end

   // Staged CD values with the current data-phase write folded in.
   always_comb begin
      nxt_cd_stage = cd_stage_ff;
      if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_CD_PHASE)) begin
         nxt_cd_stage.phase = hwdata[15:0];
      end
      if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_CD_FREQ_LO)) begin
         nxt_cd_stage.freq[15:0] = hwdata[15:0];
      end
      if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_CD_FREQ_HI)) begin
         nxt_cd_stage.freq[31:16] = hwdata[15:0];
      end
   end

   // Staged registers take every write; both frequency halves reset to zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ab_stage_ff <= {nco_pll_pkg::FREQ_HALF_RST, nco_pll_pkg::FREQ_HALF_RST,
                         nco_pll_pkg::PHASE_RST};
         cd_stage_ff <= {nco_pll_pkg::FREQ_HALF_RST, nco_pll_pkg::FREQ_HALF_RST,
                         nco_pll_pkg::PHASE_RST};
      end else begin
         ab_stage_ff <= nxt_ab_stage;
         cd_stage_ff <= nxt_cd_stage;
      end
   end

   // Auto-sync enable register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         autosync_ff <= nco_pll_pkg::ASYNC_RST;
      end else if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_AUTOSYNC)) begin
         autosync_ff <= hwdata[1:0];
      end
   end

   // Only a phase-shift write with auto-sync on, or the external sync, loads a channel.
   // The external sync loads both channels even with auto-sync off, to align several parts.
   assign ab_load = ext_mixer_sync ||
                    (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_AB_PHASE) &&
                     autosync_ff[nco_pll_pkg::ASYNC_AB_BIT]);
   assign cd_load = ext_mixer_sync ||
                    (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_CD_PHASE) &&
                     autosync_ff[nco_pll_pkg::ASYNC_CD_BIT]);

   // Active settings change all at once, taking the phase being written in that cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ab_active_ff <= {nco_pll_pkg::FREQ_HALF_RST, nco_pll_pkg::FREQ_HALF_RST,
                          nco_pll_pkg::PHASE_RST};
      end else if (ab_load) begin
         ab_active_ff <= nxt_ab_stage;
      end
   end

   // CD active settings ignore frequency-half writes until the next load.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cd_active_ff <= {nco_pll_pkg::FREQ_HALF_RST, nco_pll_pkg::FREQ_HALF_RST,
                          nco_pll_pkg::PHASE_RST};
      end else if (cd_load) begin
         cd_active_ff <= nxt_cd_stage;
      end
   end

   // One-cycle indications that a channel took new settings.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ab_loaded_ff <= 1'b0;
         cd_loaded_ff <= 1'b0;
      end else begin
         ab_loaded_ff <= ab_load;
         cd_loaded_ff <= cd_load;
      end
   end

   assign ab_mixer_loaded = ab_loaded_ff;
   assign cd_mixer_loaded = cd_loaded_ff;

   // AB oscillator.
   nco_accum #(
      .ACC_W(nco_pll_pkg::FREQ_W),
      .PHASE_W(nco_pll_pkg::PHASE_W)
   ) u_ab_nco (
      .hclk(hclk),
      .hresetn(hresetn),
      .advance(sample_strobe),
      .freq_word(ab_active_ff.freq),
      .phase_shift(ab_active_ff.phase),
      .lut_addr(ab_lut_addr)
   );

   // CD oscillator; its address is the phase shift plus the upper accumulator bits.
   nco_accum #(
      .ACC_W(nco_pll_pkg::FREQ_W),
      .PHASE_W(nco_pll_pkg::PHASE_W)
   ) u_cd_nco (
      .hclk(hclk),
      .hresetn(hresetn),
      .advance(sample_strobe),
      .freq_word(cd_active_ff.freq),
      .phase_shift(cd_active_ff.phase),
      .lut_addr(cd_lut_addr)
   );

   // Synthesiser control register; the voltage field is never written by software.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_ctrl_ff.resv_hi <= nco_pll_pkg::RESV_HI_RST;
         pll_ctrl_ff.lf_clear <= nco_pll_pkg::LF_CLEAR_RST;
         pll_ctrl_ff.ndiv_sync_ena <= nco_pll_pkg::NDIV_SYNC_RST;
         pll_ctrl_ff.pll_ena <= nco_pll_pkg::PLL_ENA_RST;
         pll_ctrl_ff.resv_lo <= nco_pll_pkg::RESV_LO_RST;
         pll_ctrl_ff.charge_pump <= nco_pll_pkg::CP_RST;
         pll_ctrl_ff.prescale <= nco_pll_pkg::PRESC_RST;
         pll_ctrl_ff.lf_volt <= nco_pll_pkg::LF_VOLT_RST;
      end else if (wr_hit(wr_pend_ff, dp_idx_ff, nco_pll_pkg::IDX_SYNTH)) begin
         // The indicator field holds its reset value; readback shows the sampled input.
         pll_ctrl_ff <= {hwdata[15:3], nco_pll_pkg::LF_VOLT_RST};
      end
   end

   // Sample the loop-filter voltage indicator for readback.
   // The sampling register costs one cycle of latency but keeps the raw pin off the read path.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lf_volt_ff <= nco_pll_pkg::LF_VOLT_RST;
      end else begin
         lf_volt_ff <= lf_volt_code;
      end
   end

   // Divider alignment passes the LVDS sync only while enabled.
   // Clearing the enable blocks the sync from the dividers one cycle later.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ndiv_sync_ff <= 1'b0;
      end else begin
         ndiv_sync_ff <= lvds_sync && pll_ctrl_ff.ndiv_sync_ena;
      end
   end

   // Decoded prescaler ratio.
   // Reset loads the ratio of the reset code, so the output is right before any write.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prescale_ratio_ff <= presc_ratio(nco_pll_pkg::PRESC_RST);
      end else begin
         prescale_ratio_ff <= presc_ratio(pll_ctrl_ff.prescale);
      end
   end

   // Synthesiser control outputs, each straight from a register, except pll_bypass, which is the inverse of the enable bit.
   assign pll_lf_clamp = pll_ctrl_ff.lf_clear;
   assign pll_enable = pll_ctrl_ff.pll_ena;
   assign pll_bypass = !pll_ctrl_ff.pll_ena;
   assign pll_ndiv_sync = ndiv_sync_ff;
   assign prescale_ratio = prescale_ratio_ff;

   // Code 10 drives neither pump, the same as code 00.
   assign cp_single = (pll_ctrl_ff.charge_pump == nco_pll_pkg::CP_SINGLE);
   assign cp_dual = (pll_ctrl_ff.charge_pump == nco_pll_pkg::CP_DUAL);

   // Read mux; unmapped indices read as zero.
   always_comb begin
      rd_word = 16'h0000;
      case (dp_idx_ff)
         nco_pll_pkg::IDX_AB_PHASE: begin
            rd_word = ab_stage_ff.phase;
         end
         nco_pll_pkg::IDX_CD_PHASE: begin
            rd_word = cd_stage_ff.phase;
         end
         nco_pll_pkg::IDX_AB_FREQ_LO: begin
            rd_word = ab_stage_ff.freq[15:0];
         end
         nco_pll_pkg::IDX_AB_FREQ_HI: begin
            rd_word = ab_stage_ff.freq[31:16];
         end
         nco_pll_pkg::IDX_CD_FREQ_LO: begin
            rd_word = cd_stage_ff.freq[15:0];
         end
         nco_pll_pkg::IDX_CD_FREQ_HI: begin
            rd_word = cd_stage_ff.freq[31:16];
         end
         nco_pll_pkg::IDX_SYNTH: begin
            rd_word = {pll_ctrl_ff[15:3], lf_volt_ff};
         end
         nco_pll_pkg::IDX_AUTOSYNC: begin
            rd_word = {14'h0000, autosync_ff};
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // Read data stands during the data phase of a read and is zero otherwise.
   assign hrdata = rd_pend_ff ? {16'h0000, rd_word} : 32'h0000_0000;

endmodule : nco_pll_config_regs

//--- verif/nco_pll_config_regs_properties.sv
// Port-level checks of the oscillator and synthesiser register bank.
`timescale 1ns/100ps
module nco_pll_config_regs_chk (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Bus signals.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Mixer load signals.
   input wire logic ext_mixer_sync,
   input wire logic ab_mixer_loaded,
   input wire logic cd_mixer_loaded,
   // Synthesiser signals.
   input wire logic lvds_sync,
   input wire logic pll_lf_clamp,
   input wire logic pll_ndiv_sync,
   input wire logic pll_enable,
   input wire logic pll_bypass,
   input wire logic cp_single,
   input wire logic cp_dual,
   input wire logic [3:0] prescale_ratio
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic dv_ff;
   logic [7:0] di_ff;
   logic [1:0] as_ff;
   logic wr_syn;
   logic ab_go;
   logic cd_go;

   // Follows each write into its data phase and mirrors the auto-sync enables.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dv_ff <= 1'b0;
         di_ff <= 8'h00;
         as_ff <= nco_pll_pkg::ASYNC_RST;
      end else begin
         dv_ff <= hsel && hready && htrans[1] && hwrite;
         di_ff <= haddr[9:2];
         if (dv_ff && di_ff == nco_pll_pkg::IDX_AUTOSYNC) begin
            as_ff <= hwdata[1:0];
         end
      end
   end

   // Data phases that update the synthesiser register or trigger a mixer load.
   assign wr_syn = dv_ff && di_ff == nco_pll_pkg::IDX_SYNTH;
   assign ab_go = dv_ff && di_ff == nco_pll_pkg::IDX_AB_PHASE && as_ff[0];
   assign cd_go = dv_ff && di_ff == nco_pll_pkg::IDX_CD_PHASE && as_ff[1];

   property p_bus;
      hreadyout && !hresp;
   endproperty
   a_bus: assert property (p_bus) else $error("bus slave not ready or not OKAY");
   property p_clamp;
      wr_syn |=> pll_lf_clamp == $past(hwdata[12]);
   endproperty
   a_clamp: assert property (p_clamp) else $error("loop filter clamp wrong");
   property p_ena;
      wr_syn |=> pll_enable == $past(hwdata[10]) && pll_bypass == !pll_enable;
   endproperty
   a_ena: assert property (p_ena) else $error("enable or bypass wrong");
   property p_cp;
      wr_syn |=> cp_single == ($past(hwdata[7:6]) == 2'h1)
         && cp_dual == ($past(hwdata[7:6]) == 2'h3);
   endproperty
   a_cp: assert property (p_cp) else $error("charge pump select wrong");
   property p_presc;
      wr_syn |-> ##2 prescale_ratio == (($past(hwdata[5:3], 2) == 3'h0) ? 4'h8
         : {1'b0, $past(hwdata[5:3], 2)});
   endproperty
   a_presc: assert property (p_presc) else $error("prescale ratio wrong");
   property p_ndiv;
      wr_syn ##1 1'b1 |=> pll_ndiv_sync == ($past(lvds_sync) && $past(hwdata[11], 2));
   endproperty
   a_ndiv: assert property (p_ndiv) else $error("divider sync wrong");
   property p_cd;
      cd_go |=> cd_mixer_loaded;
   endproperty
   a_cd: assert property (p_cd) else $error("CD phase write did not load");
   property p_ab;
      ab_go |=> ab_mixer_loaded;
   endproperty
   a_ab: assert property (p_ab) else $error("AB phase write did not load");
   property p_only;
      (cd_mixer_loaded |-> $past(cd_go) || $past(ext_mixer_sync))
         and (ab_mixer_loaded |-> $past(ab_go) || $past(ext_mixer_sync));
   endproperty
   a_only: assert property (p_only) else $error("mixer loaded without cause");

   c_cd: cover property (cd_go ##1 cd_mixer_loaded);
   c_ext: cover property (ext_mixer_sync ##1 ab_mixer_loaded);
   c_div8: cover property (wr_syn && hwdata[5:3] == 3'h0);
endmodule : nco_pll_config_regs_chk

bind nco_pll_config_regs nco_pll_config_regs_chk nco_pll_config_regs_chk_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .ext_mixer_sync(ext_mixer_sync), .ab_mixer_loaded(ab_mixer_loaded),
   .cd_mixer_loaded(cd_mixer_loaded), .lvds_sync(lvds_sync), .pll_lf_clamp(pll_lf_clamp),
   .pll_ndiv_sync(pll_ndiv_sync), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
   .cp_single(cp_single), .cp_dual(cp_dual), .prescale_ratio(prescale_ratio));

//--- verif/test_nco_pll_config_regs.sv
// Self-checking testbench of the oscillator and synthesiser register bank.
`timescale 1ns/100ps
module test_nco_pll_config_regs;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic sample_strobe = 1'b0;
   logic ext_mixer_sync = 1'b0;
   logic lvds_sync = 1'b0;
   logic [2:0] lf_volt_code = 3'h2;
   logic hreadyout, hresp, rdy_smp;
   logic [31:0] hrdata, rd_smp, d;
   logic [15:0] ab_lut_addr, cd_lut_addr;
   logic ab_mixer_loaded, cd_mixer_loaded, pll_lf_clamp, pll_ndiv_sync;
   logic pll_enable, pll_bypass, cp_single, cp_dual, ls;
   logic [3:0] prescale_ratio;
   int num_errors = 0;
   int checks = 0;
   int ab_loads = 0;
   int cd_loads = 0;
   int exp_ab = 0;
   int exp_cd = 0;
   // Bench copy of staged registers, active settings and accumulators.
   logic [15:0] sh [0:5] = '{default: 16'h0};
   logic [31:0] ab_f = 32'h0, cd_f = 32'h0, ab_acc = 32'h0, cd_acc = 32'h0;
   logic [15:0] ab_p = 16'h0, cd_p = 16'h0;
   logic [1:0] asy = 2'h3;

   nco_pll_config_regs nco_pll_config_regs_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_strobe(sample_strobe),
      .ext_mixer_sync(ext_mixer_sync), .ab_lut_addr(ab_lut_addr), .cd_lut_addr(cd_lut_addr),
      .ab_mixer_loaded(ab_mixer_loaded), .cd_mixer_loaded(cd_mixer_loaded),
      .lvds_sync(lvds_sync), .lf_volt_code(lf_volt_code), .pll_lf_clamp(pll_lf_clamp),
      .pll_ndiv_sync(pll_ndiv_sync), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
      .cp_single(cp_single), .cp_dual(cp_dual), .prescale_ratio(prescale_ratio));

   // Clock of 50 ns period.
   always #25 hclk = ~hclk;

   // Samples the bus answer at each edge and counts mixer load pulses.
   always @(posedge hclk) begin
      rd_smp <= hrdata;
      rdy_smp <= hreadyout;
      if (ab_mixer_loaded === 1'b1) ab_loads++;
      if (cd_mixer_loaded === 1'b1) cd_loads++;
   end

   task automatic step(input int n);
      repeat (n) begin
         @(posedge hclk);
         #1;
      end
   endtask : step

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         step(1);
         n++;
      end while (rdy_smp !== 1'b1 && n < 40);
      if (n >= 40) begin
         num_errors++;
         $display("[FAIL] %0t bus wait too long", $time);
      end
   endtask : wait_rdy

   // One single word transfer: address phase, then data phase.
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = rd_smp;
   endtask : xfer

   // Write that also updates the bench copy of the mixer settings.
   task automatic wr(input logic [7:0] idx, input logic [31:0] dw);
      logic [31:0] r;
      xfer(1'b1, idx, dw, r);
      if (idx >= 8'h12 && idx <= 8'h17) sh[idx - 8'h12] = dw[15:0];
      if (idx == nco_pll_pkg::IDX_AUTOSYNC) asy = dw[1:0];
      if (idx == nco_pll_pkg::IDX_AB_PHASE && asy[0]) begin
         ab_f = {sh[3], sh[2]};
         ab_p = sh[0];
         exp_ab++;
      end
      if (idx == nco_pll_pkg::IDX_CD_PHASE && asy[1]) begin
         cd_f = {sh[5], sh[4]};
         cd_p = sh[1];
         exp_cd++;
      end
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, idx, $urandom, r);
      chk(r, e);
   endtask : rd_chk

   // Runs the sample strobe for n cycles, then compares table addresses and load counts.
   task automatic strobe(input int n);
      sample_strobe <= 1'b1;
      step(n);
      sample_strobe <= 1'b0;
      ab_acc = ab_acc + ab_f * n;
      cd_acc = cd_acc + cd_f * n;
      step(3);
      chk({16'h0, ab_lut_addr}, {16'h0, ab_acc[31:16] + ab_p});
      chk({16'h0, cd_lut_addr}, {16'h0, cd_acc[31:16] + cd_p});
      chk(cd_loads, exp_cd);
      chk(ab_loads, exp_ab);
   endtask : strobe

   task automatic final_report;
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   // Cuts a hang short.
   initial begin
      #(50 * 20000);
      num_errors++;
      final_report();
   end

   // Main sequence.
   initial begin
      void'($urandom(32'he54e));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      step(1);
      for (int i = 0; i < 6; i++) rd_chk(8'h12 + 8'(i), 32'h0);
      rd_chk(nco_pll_pkg::IDX_SYNTH,
             32'h2808 | {29'h0, lf_volt_code});
      chk({27'h0, pll_bypass, prescale_ratio}, {27'h0, 1'b1, 4'h1});
      for (int i = 0; i < 6; i++) begin
         d = $urandom;
         wr(8'h12 + 8'(i), d);
         rd_chk(8'h12 + 8'(i), {16'h0, d[15:0]});
      end
      rd_chk(8'h11, 32'h0);
      wr(8'h40, $urandom);
      rd_chk(8'h40, 32'h0);
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         d[5:3] = 3'(i);
         d[7:6] = 2'(i);
         ls = 1'($urandom);
         wr(nco_pll_pkg::IDX_SYNTH, d);
         lvds_sync <= ls;
         lf_volt_code <= 3'h2 + 3'($urandom % 4);
         step(2);
         chk({26'h0, cp_dual, cp_single, prescale_ratio},
             {26'h0, d[7:6] == 2'h3, d[7:6] == 2'h1, (i == 0) ? 4'h8 : 4'(i)});
         chk({29'h0, pll_lf_clamp, pll_enable, pll_ndiv_sync},
             {29'h0, d[12], d[10], d[11] & ls});
         rd_chk(nco_pll_pkg::IDX_SYNTH, {16'h0, d[15:3], lf_volt_code});
      end
      wr(nco_pll_pkg::IDX_AB_FREQ_LO, 32'h8000);
      wr(nco_pll_pkg::IDX_AB_FREQ_HI, 32'hFFFF);
      wr(nco_pll_pkg::IDX_CD_FREQ_LO, $urandom);
      wr(nco_pll_pkg::IDX_CD_FREQ_HI, $urandom);
      strobe(5);
      wr(nco_pll_pkg::IDX_AB_PHASE, $urandom);
      wr(nco_pll_pkg::IDX_CD_PHASE, $urandom);
      strobe(1 + $urandom % 20);
      wr(nco_pll_pkg::IDX_AUTOSYNC, 32'h0);
      wr(nco_pll_pkg::IDX_CD_FREQ_HI, $urandom);
      wr(nco_pll_pkg::IDX_AB_PHASE, $urandom);
      wr(nco_pll_pkg::IDX_CD_PHASE, $urandom);
      strobe(3);
      ext_mixer_sync <= 1'b1;
      step(1);
      ext_mixer_sync <= 1'b0;
      ab_f = {sh[3], sh[2]};
      ab_p = sh[0];
      cd_f = {sh[5], sh[4]};
      cd_p = sh[1];
      exp_ab++;
      exp_cd++;
      strobe(4);
      wr(nco_pll_pkg::IDX_AUTOSYNC, 32'h3);
      wr(nco_pll_pkg::IDX_CD_PHASE, $urandom);
      wr(nco_pll_pkg::IDX_AB_PHASE, $urandom);
      strobe(1 + $urandom % 30);
      final_report();
   end
endmodule : test_nco_pll_config_regs
